// ===== core/addr_map_pkg.sv
// Overview of operation
// [RL1] lowest 512K always claimed by memory
// [RL2] 80000h-9FFFFh routable to memory or PCI
// [RL3] four attributes, reads and writes separate
// [RL4] graphics window to PCI, optionally memory
// [RL5] management space defaults A0000h, relocatable
// [RL6] expansion region: eight 16K attributed blocks
// [RL7] extended BIOS: four blocks, agent, attribute
// [RL8] top BIOS reset: bridge RW, controller off
// [RL9] low gap 1M aligned, power-of-two, excluded
// [RL10] frame buffer 1M aligned below 4G
// [RL11] software orders middle gap between others
// [RL12] high gap start/end, up to 64G
// [RL13] reclaiming raises top by low and mid gap sizes
// [RL14] high BIOS claimed by memory when enabled
// [RL15] high BIOS aliases top of ISA extended
// [RL16] APIC window reserved, no unit claims
// [RL17] APIC-to-BIOS range local unless excepted
// [RL18] management flag steers by SMM range
// [RL19] expansion aliasing folds I/O onto 100-3FFh
// [RL20] two I/O ranges forward or ignore
// [RL21] gaps to 64G, frame buffer below 4G
// [RL22] all agents alias I/O consistently
// [RL23] unmatched access claimed by nobody
package addr_map_pkg;
  localparam int ADDR_W = 36;
  localparam int MB_W = 16;
  localparam int REG_W = 32;
  localparam logic [4:0] MB_SHIFT = 5'h14;
  localparam logic [35:0] LOW_DOS_TOP = 36'h0_0007_FFFF;
  localparam logic [35:0] DOS_TOP = 36'h0_0009_FFFF;
  localparam logic [35:0] GFX_BASE = 36'h0_000A_0000;
  localparam logic [35:0] GFX_TOP = 36'h0_000B_FFFF;
  localparam logic [35:0] EXP_BASE = 36'h0_000C_0000;
  localparam logic [35:0] EXT_BASE = 36'h0_000E_0000;
  localparam logic [35:0] SYS_BASE = 36'h0_000F_0000;
  localparam logic [35:0] ONE_MB = 36'h0_0010_0000;
  localparam logic [35:0] FOUR_GB = 36'h1_0000_0000;
  localparam logic [35:0] APIC_BASE = 36'h0_FEC0_0000;
  localparam logic [35:0] APIC_TOP = 36'h0_FEC0_FFFF;
  localparam logic [35:0] MID_BASE = 36'h0_FED0_0000;
  localparam logic [35:0] HBIOS_BASE = 36'h0_FFE0_0000;
  localparam logic [35:0] ISA_ALIAS_BASE = 36'h0_00FE_0000;
  localparam logic [35:0] HBIOS_ALIAS_MASK = 36'h0_0001_FFFF;
  localparam logic [15:0] SMM_BASE_RST = 16'h000A;
  localparam logic [15:0] SMM_SIZE_RST = 16'h0001;
  localparam logic [15:0] IO_ALIAS_MASK = 16'h03FF;
  localparam logic [15:0] IO_EXP_MIN = 16'h0400;
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  localparam logic [3:0] ADDR_COMPAT = 4'h1;
  localparam logic [3:0] ADDR_LOWGAP = 4'h2;
  localparam logic [3:0] ADDR_MIDGAP = 4'h3;
  localparam logic [3:0] ADDR_HIGAP = 4'h4;
  localparam logic [3:0] ADDR_FBUF = 4'h5;
  localparam logic [3:0] ADDR_SMM = 4'h6;
  localparam logic [3:0] ADDR_IO0 = 4'h7;
  localparam logic [3:0] ADDR_IO1 = 4'h8;
  localparam logic [3:0] ADDR_TOP = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'hA;
  localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;
  localparam logic [31:0] COMPAT_RST_BRIDGE = 32'h1000_0000;
  localparam logic [31:0] COMPAT_RST_MEM = 32'h0000_0000;
  localparam logic [31:0] TOP_RST = 32'h0000_0000;
  localparam logic [31:0] SMM_RST = {SMM_BASE_RST, SMM_SIZE_RST};

  typedef enum logic [1:0] {
    ATTR_OFF = 2'b00,
    ATTR_RW = 2'b01,
    ATTR_WO = 2'b10,
    ATTR_RO = 2'b11
  } attr_type;

  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_DRAM = 2'b01,
    TGT_PCI = 2'b10
  } target_type;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_write;
    logic mgmt;
    logic [35:0] addr;
  } request_type;

  typedef struct packed {
    logic valid;
    target_type target;
    logic [35:0] addr;
  } decision_type;
endpackage : addr_map_pkg

// ===== core/host_address_map_decoder.sv
module host_address_map_decoder #(
  parameter bit BRIDGE_ROLE = 1'b1,
  parameter bit COMPAT_BRIDGE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire addr_map_pkg::request_type req,
  output addr_map_pkg::decision_type dec,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // global: [0] gfx as memory, [1] reclaim, [2] hbios en, [3] apic rng en, [4] isa bridged,
  // [5] io alias, [6] low gap en, [7] mid gap en, [8] high gap en, [9] fbuf en, [10] dos hi to pci,
  // [11] io0 en, [12] io1 en
  // compat: [15:0] eight expansion attrs, [23:16] ext bios attrs, [27:24] ext bios owner,
  // [29:28] sys bios attr, [31:30] dos hi attr
  logic [31:0] global_reg, compat_reg, lowgap_reg, midgap_reg, higap_reg, fbuf_reg, smm_reg;
  logic [31:0] io0_reg, io1_reg, top_reg;
  logic [31:0] hits_reg, rdata_reg;
  addr_map_pkg::decision_type dec_reg;

  function automatic logic attr_ok(input logic [1:0] a, input logic wr);
    attr_ok = (a == addr_map_pkg::ATTR_RW) || (wr && a == addr_map_pkg::ATTR_WO) ||
      (!wr && a == addr_map_pkg::ATTR_RO);
  endfunction : attr_ok

  // gap field: [15:0] base in MB, [18:16] size code: size = 1 << code MB, code 0..5
  function automatic logic gap_hit(input logic [35:0] a, input logic [31:0] g);
    logic [35:0] base;
    logic [35:0] size;
    base = {4'h0, g[15:0], 16'h0000} << 4;
    size = addr_map_pkg::ONE_MB << g[18:16];
    gap_hit = (g[18:16] <= 3'd5) && (a >= base) && (a < base + size);
  endfunction : gap_hit

  function automatic logic [35:0] gap_size(input logic en, input logic [31:0] g);
    gap_size = en ? (addr_map_pkg::ONE_MB << g[18:16]) : 36'h0_0000_0000;
  endfunction : gap_size

  wire logic wr = req.is_write;
  wire logic [35:0] a = req.addr;
  wire logic [15:0] a_mb = a[35:20];
  wire logic in_low = a <= addr_map_pkg::LOW_DOS_TOP;
  wire logic in_dos_hi = !in_low && a <= addr_map_pkg::DOS_TOP;
  wire logic in_gfx = a >= addr_map_pkg::GFX_BASE && a <= addr_map_pkg::GFX_TOP;
  wire logic in_exp = a >= addr_map_pkg::EXP_BASE && a < addr_map_pkg::EXT_BASE;
  wire logic in_ext = a >= addr_map_pkg::EXT_BASE && a < addr_map_pkg::SYS_BASE;
  wire logic in_sys = a >= addr_map_pkg::SYS_BASE && a < addr_map_pkg::ONE_MB;
  wire logic in_apic = a >= addr_map_pkg::APIC_BASE && a <= addr_map_pkg::APIC_TOP;
  wire logic in_mid = a >= addr_map_pkg::MID_BASE && a < addr_map_pkg::HBIOS_BASE;
  wire logic in_hbios = a >= addr_map_pkg::HBIOS_BASE && a < addr_map_pkg::FOUR_GB;
  wire logic [2:0] exp_idx = a[16:14];
  wire logic [1:0] ext_idx = a[15:14];
  wire logic [1:0] exp_attr = compat_reg[{exp_idx, 1'b0} +: 2]; // RL6
  wire logic [1:0] ext_attr = {compat_reg[17 + 2 * ext_idx], compat_reg[16 + 2 * ext_idx]}; // RL7
  wire logic ext_mine = compat_reg[24 + ext_idx] == BRIDGE_ROLE; // RL7
  wire logic [1:0] sys_attr = compat_reg[29:28];
  wire logic [1:0] dos_attr = compat_reg[31:30];
  wire logic low_gap = global_reg[6] && gap_hit(a, lowgap_reg); // RL9
  wire logic mid_gap = global_reg[7] && gap_hit(a, midgap_reg); // RL21
  // high gap from start/end in MB, inclusive of start, exclusive of end
  wire logic hi_gap = global_reg[8] && a_mb >= higap_reg[15:0] && a_mb < higap_reg[31:16]; // RL12
  wire logic fb_hit = global_reg[9] && a < addr_map_pkg::FOUR_GB && gap_hit(a, fbuf_reg); // RL10 RL21
  wire logic any_gap = low_gap || mid_gap || hi_gap || (BRIDGE_ROLE && fb_hit);
  // reclaim: hidden dram moves above the programmed top
  wire logic [35:0] top_base = {top_reg[15:0], 20'h0_0000};
  wire logic [35:0] top_eff = top_base + (global_reg[1] ? (gap_size(global_reg[6], lowgap_reg) + // RL13
    gap_size(global_reg[7], midgap_reg)) : 36'h0_0000_0000);
  wire logic below_top = a < top_eff;
  // end computed one bit wider so a range reaching the top block does not wrap
  wire logic smm_hit = a_mb == 16'h0000 && a[19:16] >= smm_reg[19:16] && // RL5
    {1'b0, a[19:16]} < ({1'b0, smm_reg[19:16]} + {1'b0, smm_reg[3:0]});
  wire logic smm_steer = req.mgmt && smm_hit; // RL18
  // i/o: fold expansion aliases before compare, ranges are [15:0] base [31:16] limit, io enables in global
  wire logic io_exp = a[15:0] >= addr_map_pkg::IO_EXP_MIN && a[9:8] != 2'b00;
  wire logic [15:0] io_a = (global_reg[5] && io_exp) ? (a[15:0] & addr_map_pkg::IO_ALIAS_MASK) : a[15:0]; // RL19
  wire logic io0_hit = global_reg[11] && io_a >= io0_reg[15:0] && io_a <= io0_reg[31:16]; // RL20
  wire logic io1_hit = global_reg[12] && io_a >= io1_reg[15:0] && io_a <= io1_reg[31:16]; // RL20

  // memory-controller view: claim dram
  logic mem_claim;
  always_comb begin
    mem_claim = 1'b0;
    if (in_low) begin
      mem_claim = 1'b1; // RL1
    end else if (smm_steer) begin
      mem_claim = 1'b1;
    end else if (in_dos_hi) begin
      mem_claim = !global_reg[10] && attr_ok(dos_attr, wr); // RL2 RL3
    end else if (in_gfx) begin
      mem_claim = global_reg[0]; // RL4
    end else if (in_exp) begin
      mem_claim = attr_ok(exp_attr, wr); // RL6
    end else if (in_ext) begin
      mem_claim = ext_mine && attr_ok(ext_attr, wr); // RL7
    end else if (in_sys) begin
      mem_claim = attr_ok(sys_attr, wr); // RL8
    end else if (in_apic) begin
      mem_claim = 1'b0; // RL16
    end else if (in_hbios) begin
      mem_claim = global_reg[2]; // RL14
    end else if (in_mid) begin
      mem_claim = global_reg[3] && below_top && !(!global_reg[2] && any_gap); // RL17
    end else begin
      mem_claim = below_top && !any_gap; // RL9
    end
  end

  // bridge view: claim for pci
  logic pci_claim;
  always_comb begin
    pci_claim = 1'b0;
    if (in_low) begin
      pci_claim = 1'b0; // RL1
    end else if (smm_steer) begin
      pci_claim = 1'b0;
    end else if (in_dos_hi) begin
      pci_claim = global_reg[10] && attr_ok(dos_attr, wr); // RL2
    end else if (in_gfx) begin
      pci_claim = !global_reg[0]; // RL4
    end else if (in_exp) begin
      pci_claim = attr_ok(exp_attr, wr);
    end else if (in_ext) begin
      pci_claim = ext_mine && attr_ok(ext_attr, wr);
    end else if (in_sys) begin
      pci_claim = attr_ok(sys_attr, wr);
    end else if (in_apic) begin
      pci_claim = 1'b0; // RL16
    end else if (in_hbios) begin
      pci_claim = !global_reg[2];
    end else begin
      pci_claim = any_gap;
    end
  end

  wire logic claim = req.is_io ? (BRIDGE_ROLE && (io0_hit || io1_hit)) : // RL20
    (BRIDGE_ROLE ? pci_claim : mem_claim);
  wire logic [35:0] out_addr = (!req.is_io && in_hbios && global_reg[4]) ? // RL15
    (addr_map_pkg::ISA_ALIAS_BASE | (a & addr_map_pkg::HBIOS_ALIAS_MASK)) : a;
  wire addr_map_pkg::target_type tgt = !claim ? addr_map_pkg::TGT_NONE : // RL23
    (BRIDGE_ROLE ? addr_map_pkg::TGT_PCI : addr_map_pkg::TGT_DRAM);

  wire logic [31:0] status_now = {26'h000_0000, smm_steer, hi_gap, mid_gap, low_gap, fb_hit, claim};
  wire logic [31:0] rd_mux =
    reg_addr == addr_map_pkg::ADDR_GLOBAL ? global_reg :
    reg_addr == addr_map_pkg::ADDR_COMPAT ? compat_reg :
    reg_addr == addr_map_pkg::ADDR_LOWGAP ? lowgap_reg :
    reg_addr == addr_map_pkg::ADDR_MIDGAP ? midgap_reg :
    reg_addr == addr_map_pkg::ADDR_HIGAP ? higap_reg :
    reg_addr == addr_map_pkg::ADDR_FBUF ? fbuf_reg :
    reg_addr == addr_map_pkg::ADDR_SMM ? smm_reg :
    reg_addr == addr_map_pkg::ADDR_IO0 ? io0_reg :
    reg_addr == addr_map_pkg::ADDR_IO1 ? io1_reg :
    reg_addr == addr_map_pkg::ADDR_TOP ? top_reg :
    reg_addr == addr_map_pkg::ADDR_STATUS ? hits_reg : 32'h0000_0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      global_reg <= addr_map_pkg::GLOBAL_RST;
      compat_reg <= (BRIDGE_ROLE && COMPAT_BRIDGE) ? addr_map_pkg::COMPAT_RST_BRIDGE :
        addr_map_pkg::COMPAT_RST_MEM; // RL8
      lowgap_reg <= 32'h0000_0000;
      midgap_reg <= 32'h0000_0000;
      higap_reg <= 32'h0000_0000;
      fbuf_reg <= 32'h0000_0000;
      smm_reg <= addr_map_pkg::SMM_RST; // RL5
      io0_reg <= 32'h0000_0000;
      io1_reg <= 32'h0000_0000;
      top_reg <= addr_map_pkg::TOP_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        addr_map_pkg::ADDR_GLOBAL: global_reg <= reg_wdata;
        addr_map_pkg::ADDR_COMPAT: compat_reg <= reg_wdata;
        addr_map_pkg::ADDR_LOWGAP: lowgap_reg <= reg_wdata;
        addr_map_pkg::ADDR_MIDGAP: midgap_reg <= reg_wdata;
        addr_map_pkg::ADDR_HIGAP: higap_reg <= reg_wdata;
        addr_map_pkg::ADDR_FBUF: fbuf_reg <= reg_wdata;
        addr_map_pkg::ADDR_SMM: smm_reg <= reg_wdata;
        addr_map_pkg::ADDR_IO0: io0_reg <= reg_wdata;
        addr_map_pkg::ADDR_IO1: io1_reg <= reg_wdata;
        addr_map_pkg::ADDR_TOP: top_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dec_reg <= '0;
      hits_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      dec_reg <= '{valid: req.valid, target: req.valid ? tgt : addr_map_pkg::TGT_NONE, addr: out_addr};
      if (req.valid) begin
        hits_reg <= status_now;
      end
      rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign dec = dec_reg;
  assign reg_rdata = rdata_reg;

  a_low_dos_claim: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    (req.valid && !req.is_io && req.addr <= addr_map_pkg::LOW_DOS_TOP && !BRIDGE_ROLE)
    |=> dec.target == addr_map_pkg::TGT_DRAM)
    else $error("low dos not claimed");
  a_apic_unclaimed: assert property (@(posedge clk_sys) disable iff (rst) // RL16
    (req.valid && !req.is_io && req.addr >= addr_map_pkg::APIC_BASE && req.addr <= addr_map_pkg::APIC_TOP)
    |=> dec.target == addr_map_pkg::TGT_NONE)
    else $error("apic window claimed");
  a_idle_no_target: assert property (@(posedge clk_sys) disable iff (rst) // RL23
    !req.valid |=> dec.target == addr_map_pkg::TGT_NONE)
    else $error("target without request");
  a_io_disabled: assert property (@(posedge clk_sys) disable iff (rst) // RL20
    (req.valid && req.is_io && !global_reg[11] && !global_reg[12]) |=> dec.target == addr_map_pkg::TGT_NONE)
    else $error("io claimed with ranges off");
  a_ro_write_block: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    (req.valid && !req.is_io && !req.mgmt && req.is_write && req.addr >= addr_map_pkg::EXP_BASE &&
     req.addr < addr_map_pkg::EXT_BASE && exp_attr == addr_map_pkg::ATTR_RO)
    |=> dec.target == addr_map_pkg::TGT_NONE)
    else $error("write to read-only block claimed");
  a_gfx_route: assert property (@(posedge clk_sys) disable iff (rst) // RL4
    (req.valid && !req.is_io && in_gfx && !smm_steer && !global_reg[0] && BRIDGE_ROLE)
    |=> dec.target == addr_map_pkg::TGT_PCI)
    else $error("graphics not forwarded");
  a_hbios_alias: assert property (@(posedge clk_sys) disable iff (rst) // RL15
    (req.valid && !req.is_io && in_hbios && global_reg[4])
    |=> dec.addr[35:17] == addr_map_pkg::ISA_ALIAS_BASE[35:17])
    else $error("high bios not aliased");
  a_read_latency: assert property (@(posedge clk_sys) disable iff (rst) // RL5
    (reg_rd && reg_addr == addr_map_pkg::ADDR_SMM && !$past(reg_wr)) |=> reg_rdata == $past(smm_reg))
    else $error("read data wrong");
  a_smm_steer: assert property (@(posedge clk_sys) disable iff (rst) // RL18
    (req.valid && !req.is_io && req.mgmt && smm_hit)
    |=> dec.target == (BRIDGE_ROLE ? addr_map_pkg::TGT_NONE : addr_map_pkg::TGT_DRAM))
    else $error("management access not steered");
endmodule : host_address_map_decoder

// ===== dv/host_agent_model.sv
module host_agent_model (
  input wire logic clk_sys,
  output addr_map_pkg::request_type req
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req = '0;

  // one request per call, raised just after an edge and held for one cycle
  task automatic send(input logic io, input logic wr, input logic mg, input logic [35:0] a);
    @(posedge clk_sys);
    // i/o addresses go out unfolded, the same way from every agent
    req <= '{valid: 1'b1, is_io: io, is_write: wr, mgmt: mg, addr: a};
    @(posedge clk_sys);
    // released bus shows the inverse with mgmt low, so a stale address never matches by luck
    req <= '{valid: 1'b0, is_io: ~io, is_write: ~wr, mgmt: 1'b0, addr: ~a};
  endtask : send
endmodule : host_agent_model

// ===== dv/host_address_map_decoder_tb.sv
module host_address_map_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] N = 2'b00;
  localparam logic [1:0] D = 2'b01;
  localparam logic [1:0] P = 2'b10;
  localparam logic [1:0] X = 2'b11;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] rdata_b;
  logic [31:0] rdata_m;
  addr_map_pkg::request_type req;
  addr_map_pkg::decision_type dec_b;
  addr_map_pkg::decision_type dec_m;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  host_agent_model agent_u (.clk_sys(clk_sys), .req(req));
  host_address_map_decoder #(.BRIDGE_ROLE(1'b1), .COMPAT_BRIDGE(1'b1)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .req(req), .dec(dec_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata_b));
  host_address_map_decoder #(.BRIDGE_ROLE(1'b0), .COMPAT_BRIDGE(1'b0)) mem_ctl_u (.clk_sys(clk_sys), .rst(rst),
    .req(req), .dec(dec_m), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata_m));

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk_tgt(input string n, input addr_map_pkg::target_type e, input addr_map_pkg::target_type s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", n, e, s);
    end
  endtask : chk_tgt

  task automatic chk_val(input string n, input logic [35:0] e, input logic [35:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk_val

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic glb(input logic [31:0] d);
    wr_reg(addr_map_pkg::ADDR_GLOBAL, d);
  endtask : glb

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] eb, input logic [31:0] em);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk_val("bridge read data", {4'h0, eb}, {4'h0, rdata_b});
    chk_val("memctl read data", {4'h0, em}, {4'h0, rdata_m});
  endtask : rd_chk

  // X leaves that agent's answer unchecked where its claim is left open
  task automatic acc(input logic io, input logic wr, input logic mg, input logic [35:0] a,
    input logic [1:0] eb, input logic [1:0] em);
    agent_u.send(io, wr, mg, a);
    #1;
    chk_val("decision valid", 36'h0_0000_0003, {34'h0, dec_b.valid, dec_m.valid});
    if (eb !== X) chk_tgt("bridge target", addr_map_pkg::target_type'(eb), dec_b.target);
    if (em !== X) chk_tgt("memctl target", addr_map_pkg::target_type'(em), dec_m.target);
  endtask : acc

  task automatic t_reset();
    rd_chk(addr_map_pkg::ADDR_COMPAT, addr_map_pkg::COMPAT_RST_BRIDGE, addr_map_pkg::COMPAT_RST_MEM);
    rd_chk(addr_map_pkg::ADDR_SMM, addr_map_pkg::SMM_RST, addr_map_pkg::SMM_RST);
    rd_chk(addr_map_pkg::ADDR_GLOBAL, 32'h0000_0000, 32'h0000_0000);
    rd_chk(4'hB, 32'h0000_0000, 32'h0000_0000);
    acc(1'b0, 1'b0, 1'b0, 36'h0_000F_0000, P, N);
    acc(1'b0, 1'b1, 1'b0, 36'h0_000F_0000, P, N);
    acc(1'b0, 1'b1, 1'b0, 36'h0_0007_FFFF, N, D);
    acc(1'b0, 1'b0, 1'b1, 36'h0_000A_0000, N, D);
    acc(1'b0, 1'b0, 1'b0, 36'h0_000A_0000, P, N);
    rd_chk(addr_map_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
    wr_reg(addr_map_pkg::ADDR_TOP, 32'h0000_0040);
  endtask : t_reset

  task automatic t_compat();
    logic [1:0] at;
    logic [35:0] a;
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 8; b++) begin
        at = 2'(m);
        a = addr_map_pkg::EXP_BASE + 36'(b) * 36'h0_0000_4000;
        wr_reg(addr_map_pkg::ADDR_COMPAT, 32'(at) << (2 * b));
        acc(1'b0, 1'b0, 1'b0, a, X, (at == addr_map_pkg::ATTR_RW || at == addr_map_pkg::ATTR_RO) ? D : N);
        acc(1'b0, 1'b1, 1'b0, a, X, (at == addr_map_pkg::ATTR_RW || at == addr_map_pkg::ATTR_WO) ? D : N);
        acc(1'b0, 1'b1, 1'b0, addr_map_pkg::EXP_BASE + 36'((b + 1) % 8) * 36'h0_0000_4000, X, N);
      end
    end
    wr_reg(addr_map_pkg::ADDR_COMPAT, 32'h0001_0000);
    acc(1'b0, 1'b0, 1'b0, addr_map_pkg::EXT_BASE, X, D);
    wr_reg(addr_map_pkg::ADDR_COMPAT, 32'h0101_0000);
    acc(1'b0, 1'b0, 1'b0, addr_map_pkg::EXT_BASE, P, N);
  endtask : t_compat

  task automatic t_gfx_smm();
    wr_reg(addr_map_pkg::ADDR_SMM, 32'h000C_0001);
    acc(1'b0, 1'b0, 1'b1, 36'h0_000C_0000, X, D);
    acc(1'b0, 1'b0, 1'b1, 36'h0_000A_0000, P, N);
    glb(32'h0000_0001);
    acc(1'b0, 1'b0, 1'b0, 36'h0_000B_0000, N, D);
    wr_reg(addr_map_pkg::ADDR_COMPAT, 32'h4000_0000);
    glb(32'h0000_0400);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0009_0000, P, N);
    glb(32'h0000_0000);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0009_0000, N, D);
    wr_reg(addr_map_pkg::ADDR_COMPAT, 32'h0000_0000);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0009_0000, N, N);
  endtask : t_gfx_smm

  task automatic t_gap();
    wr_reg(addr_map_pkg::ADDR_LOWGAP, 32'h0002_0010);
    glb(32'h0000_0040);
    acc(1'b0, 1'b0, 1'b0, 36'h0_00F0_0000, X, D);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0110_0000, X, N);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0140_0000, X, D);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0410_0000, X, N);
    glb(32'h0000_0042);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0410_0000, X, D);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0440_0000, X, N);
    wr_reg(addr_map_pkg::ADDR_MIDGAP, 32'h0001_0030);
    glb(32'h0000_0080);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0310_0000, P, N);
    glb(32'h0000_0082);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0410_0000, N, D);
    wr_reg(addr_map_pkg::ADDR_FBUF, 32'h0000_0020);
    glb(32'h0000_0200);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0208_0000, P, X);
    acc(1'b0, 1'b0, 1'b0, 36'h0_0210_0000, N, X);
    wr_reg(addr_map_pkg::ADDR_HIGAP, 32'h1010_1000);
    glb(32'h0000_0100);
    acc(1'b0, 1'b0, 1'b0, 36'h1_0080_0000, P, X);
    acc(1'b0, 1'b0, 1'b0, 36'h1_0100_0000, N, X);
  endtask : t_gap

  task automatic t_io();
    wr_reg(addr_map_pkg::ADDR_IO0, 32'h031F_0300);
    wr_reg(addr_map_pkg::ADDR_IO1, 32'h0107_0100);
    glb(32'h0000_1800);
    acc(1'b1, 1'b0, 1'b0, 36'h0_0000_0310, P, N);
    acc(1'b1, 1'b1, 1'b0, 36'h0_0000_0104, P, N);
    acc(1'b1, 1'b0, 1'b0, 36'h0_0000_0320, N, N);
    acc(1'b1, 1'b0, 1'b0, 36'h0_0000_0710, N, N);
    glb(32'h0000_1820);
    acc(1'b1, 1'b0, 1'b0, 36'h0_0000_0710, P, N);
    glb(32'h0000_0020);
    acc(1'b1, 1'b0, 1'b0, 36'h0_0000_0310, N, N);
  endtask : t_io

  task automatic t_high();
    wr_reg(addr_map_pkg::ADDR_TOP, 32'h0000_1000);
    glb(32'h0000_0004);
    acc(1'b0, 1'b0, 1'b0, 36'h0_FFF0_0000, X, D);
    glb(32'h0000_0000);
    acc(1'b0, 1'b0, 1'b0, 36'h0_FFF0_0000, X, N);
    acc(1'b0, 1'b0, 1'b0, 36'h0_FEC0_1000, N, N);
    glb(32'h0000_0008);
    acc(1'b0, 1'b0, 1'b0, 36'h0_FED0_0000, X, D);
    glb(32'h0000_0010);
    acc(1'b0, 1'b0, 1'b0, 36'h0_FFFF_0000, X, X);
    chk_val("alias address", addr_map_pkg::ISA_ALIAS_BASE | 36'h0_0001_0000, dec_b.addr);
  endtask : t_high

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_compat();
    t_gfx_smm();
    t_gap();
    t_io();
    t_high();
    test_done();
  end
endmodule : host_address_map_decoder_tb
